// >>> rtl/bsac_pkg.sv
// constants and types shared by the burst sram access control block
// Functional notes
// - idle is default, no acknowledge asserted
// - preempted instruction burst passes idle one cycle
// - instruction select needs request, space, block select zero
// - data select needs request, space, top bit one
// - enter instruction state when selected, data idle
// - data select exits instruction state immediately
// - foreign instruction request exits instruction state
// - enter data state when selected, instruction idle
// - instruction select without late burst ends data
// - foreign data request exits data state
// - load captures counter and upper register
// - load blocked by the opposite access state
// - load blocked after matching delayed load
// - load is combinational in first cycle
// - delayed instruction load flag, registered
// - delayed data load flag, registered
// - count needs late burst and matching state
// - no counting after invalid bus cycle
// - one cycle delayed acknowledge copies kept
// - instruction ready from delayed load or burst
// - instruction ready blocked after invalid bus
// - data ready mirrors instruction ready
// - burst requests and bus invalid registered first
// - write strobe from ready, write, clock low
// - low address counts, high address registered
package bsac_pkg;

  // word address fields taken from the processor address
  localparam int ADDR_LO_POS = 2;
  localparam int ADDR_LO_W = 8;
  localparam int ADDR_HI_POS = 10;
  localparam int ADDR_HI_W = 8;
  localparam int ADDR_SEL_POS = 29;
  localparam int ADDR_SEL_W = 3;

  // block address seen on each bus
  localparam logic [2:0] INSTR_BLOCK_SEL = 3'h0;
  localparam logic [2:0] DATA_BLOCK_SEL = 3'h4;

  // request type codes for instruction/data space
  localparam logic INSTR_TYPE_ID_SPACE = 1'h0;
  localparam logic [1:0] DATA_TYPE_ID_SPACE = 2'h0;

  // read/write line level meaning read
  localparam logic RW_READ = 1'h1;

  // reset values of the delayed flags
  localparam logic FLAG_RESET = 1'h0;

  // interface state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA
  } bsac_state_type;

  // late copies of bus signals, one cycle old
  typedef struct packed {
    logic instr_burst_request_q;
    logic data_burst_request_q;
    logic bus_invalid_q;
  } bsac_late_type;

  // one cycle delayed acknowledges
  typedef struct packed {
    logic instr_ack_delayed;
    logic data_ack_delayed;
  } bsac_ack_type;

endpackage

// >>> rtl/bsac_late_capture.sv
// registers the late bus signals and the acknowledge copies
`timescale 1ns/1ps
module bsac_late_capture (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_instr_burst_request,
  input wire logic i_data_burst_request,
  input wire logic i_bus_invalid,
  input wire logic i_instr_burst_ack,
  input wire logic i_data_burst_ack,
  output bsac_pkg::bsac_late_type o_late,
  output bsac_pkg::bsac_ack_type o_ack
);

  // burst requests arrive too late for logic, so only copies are used
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_late <= '0;
    end else begin
      o_late.instr_burst_request_q <= i_instr_burst_request;
      o_late.data_burst_request_q <= i_data_burst_request;
      o_late.bus_invalid_q <= i_bus_invalid;
    end
  end

  // acknowledge copies feed the ready terms
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= '0;
    end else begin
      o_ack.instr_ack_delayed <= i_instr_burst_ack;
      o_ack.data_ack_delayed <= i_data_burst_ack;
    end
  end

endmodule

// >>> rtl/bsac_addr_counter.sv
// loadable low address counter with registered upper address
`timescale 1ns/1ps
module bsac_addr_counter #(
  parameter int LO_W = 8,
  parameter int HI_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_load,
  input wire logic i_count,
  input wire logic [LO_W-1:0] i_addr_lo,
  input wire logic [HI_W-1:0] i_addr_hi,
  output logic [LO_W+HI_W-1:0] o_addr
);

  logic [LO_W-1:0] lo_q; // counting part
  logic [HI_W-1:0] hi_q; // held part, processor reloads at block edges

  // low part: load wins over count, wraps at its width
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo_q <= '0;
    end else if (i_load) begin
      lo_q <= i_addr_lo;
    end else if (i_count) begin
      lo_q <= LO_W'(lo_q + 1'b1);
    end
  end

  // upper part is never counted
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_q <= '0;
    end else if (i_load) begin
      hi_q <= i_addr_hi;
    end
  end

  assign o_addr = {hi_q, lo_q};

endmodule

// >>> rtl/bsac_burst_sram_ctrl.sv
// burst sram access control: select decode, state machine, load, count, ready
`timescale 1ns/1ps
module bsac_burst_sram_ctrl #(
  parameter int LO_W = bsac_pkg::ADDR_LO_W,
  parameter int HI_W = bsac_pkg::ADDR_HI_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [31:0] i_addr,
  input wire logic i_instr_request,
  input wire logic i_instr_request_type,
  input wire logic i_data_request,
  input wire logic i_data_request_type_lo,
  input wire logic i_data_request_type_hi,
  input wire logic i_instr_burst_request,
  input wire logic i_data_burst_request,
  input wire logic i_bus_invalid,
  input wire logic i_test_takeover,
  input wire logic i_read_write,
  output logic o_instr_burst_ack,
  output logic o_data_burst_ack,
  output logic o_instr_ready,
  output logic o_data_ready,
  output logic o_data_oe,
  output logic o_mem_we_b,
  output logic [LO_W+HI_W-1:0] o_mem_addr
);

  // state and delayed flags
  bsac_pkg::bsac_state_type state_q; // interface state
  bsac_pkg::bsac_state_type state_d; // next state
  logic instr_load_delayed_q; // load for own instruction fetch
  logic data_load_delayed_q; // load for own data access

  // late copies from the capture block
  bsac_pkg::bsac_late_type late; // requests and invalid, one cycle old
  bsac_pkg::bsac_ack_type ack_dly; // acknowledges, one cycle old

  // combinational terms
  logic instr_access_state; // instruction burst active or suspended
  logic data_access_state; // data burst active or suspended
  logic instr_select; // valid instruction request to this block
  logic data_select; // valid data request to this block
  logic instr_exit_term; // leave instruction state
  logic data_exit_term; // leave data state
  logic addr_load; // load address on next edge
  logic addr_increment; // count address on next edge
  logic instr_ready; // instruction data valid
  logic data_ready; // data valid or written
  logic write_term; // write cycle completing this cycle

  // block select field of the address
  logic [bsac_pkg::ADDR_SEL_W-1:0] addr_sel;
  assign addr_sel = i_addr[bsac_pkg::ADDR_SEL_POS +: bsac_pkg::ADDR_SEL_W];

  // state decode
  assign instr_access_state = (state_q == bsac_pkg::ST_INSTR);
  assign data_access_state = (state_q == bsac_pkg::ST_DATA);

  // the acknowledge pins are decoded straight from the state register
  assign o_instr_burst_ack = instr_access_state;
  assign o_data_burst_ack = data_access_state;

  // instruction select: space check and test takeover both gate it
  always_comb begin
    instr_select = i_instr_request
      && (i_instr_request_type == bsac_pkg::INSTR_TYPE_ID_SPACE)
      && !i_test_takeover
      && (addr_sel == bsac_pkg::INSTR_BLOCK_SEL);
  end

  // data select: data window sits at a different base than fetches
  always_comb begin
    data_select = i_data_request
      && ({i_data_request_type_hi, i_data_request_type_lo}
          == bsac_pkg::DATA_TYPE_ID_SPACE)
      && !i_test_takeover
      && (addr_sel == bsac_pkg::DATA_BLOCK_SEL);
  end

  // exit terms
  always_comb begin
    // data wins over an instruction fetch in progress
    instr_exit_term = data_select
      || (i_instr_request && !instr_select);
    // fetch waits until the data burst stops requesting
    data_exit_term = (instr_select && !late.data_burst_request_q)
      || (i_data_request && !data_select);
  end

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bsac_pkg::ST_IDLE: begin
        // both selected at once: data goes first, as it would preempt anyway
        if (data_select) begin
          state_d = bsac_pkg::ST_DATA;
        end else if (instr_select) begin
          state_d = bsac_pkg::ST_INSTR;
        end
      end
      bsac_pkg::ST_INSTR: begin
        // preemption goes to idle, never straight to data
        if (instr_exit_term) begin
          state_d = bsac_pkg::ST_IDLE;
        end
      end
      bsac_pkg::ST_DATA: begin
        // held until a data exit condition
        if (data_exit_term) begin
          state_d = bsac_pkg::ST_IDLE;
        end
      end
      default: begin
        // two-bit code has one illegal value
        state_d = bsac_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= bsac_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // load: combinational so it acts in the request's first cycle
  always_comb begin
    addr_load = (!data_access_state && i_instr_request
                 && !instr_load_delayed_q)
      || (!instr_access_state && i_data_request
          && !data_load_delayed_q);
  end

  // delayed instruction load marks the ready cycle of a new fetch
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      instr_load_delayed_q <= bsac_pkg::FLAG_RESET;
    end else begin
      instr_load_delayed_q <= !data_access_state && instr_select
        && addr_load;
    end
  end

  // delayed data load, mirror of the instruction flag
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_load_delayed_q <= bsac_pkg::FLAG_RESET;
    end else begin
      data_load_delayed_q <= !instr_access_state && data_select
        && addr_load;
    end
  end

  // count: burst requests are meaningless after an invalid bus cycle
  always_comb begin
    addr_increment = !late.bus_invalid_q
      && ((late.instr_burst_request_q && instr_access_state)
          || (late.data_burst_request_q && data_access_state));
  end

  // ready terms; the ack copy stops a stale burst request after preemption
  always_comb begin
    instr_ready = !late.bus_invalid_q
      && (instr_load_delayed_q
          || (late.instr_burst_request_q
              && ack_dly.instr_ack_delayed));
    data_ready = !late.bus_invalid_q
      && (data_load_delayed_q
          || (late.data_burst_request_q
              && ack_dly.data_ack_delayed));
  end

  // ready must be combinational: the registered burst request
  // only exists in the cycle where ready is due
  assign o_instr_ready = instr_ready;
  assign o_data_ready = data_ready;

  // read buffer enable only on read cycles
  assign o_data_oe = data_ready && (i_read_write == bsac_pkg::RW_READ);

  // write strobe: active low, only in the low half of the clock,
  // so it releases right at the rising edge and gives one pulse per write
  assign write_term = data_ready && (i_read_write != bsac_pkg::RW_READ);
  assign o_mem_we_b = !(write_term && !i_clk);

  // late signal and ack copy registers
  bsac_late_capture u_late (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_instr_burst_request(i_instr_burst_request),
    .i_data_burst_request(i_data_burst_request),
    .i_bus_invalid(i_bus_invalid),
    .i_instr_burst_ack(instr_access_state),
    .i_data_burst_ack(data_access_state),
    .o_late(late),
    .o_ack(ack_dly)
  );

  // memory word address
  bsac_addr_counter #(
    .LO_W(LO_W),
    .HI_W(HI_W)
  ) u_addr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(addr_load),
    .i_count(addr_increment),
    .i_addr_lo(i_addr[bsac_pkg::ADDR_LO_POS +: LO_W]),
    .i_addr_hi(i_addr[bsac_pkg::ADDR_HI_POS +: HI_W]),
    .o_addr(o_mem_addr)
  );

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // idle never shows an acknowledge
  property p_idle_no_ack;
    (state_q == bsac_pkg::ST_IDLE) |-> !o_instr_burst_ack && !o_data_burst_ack;
  endproperty
  a_idle_no_ack: assert property (p_idle_no_ack)
    else $error("ack asserted in idle");

  // preemption: instruction, then one idle cycle
  sequence s_preempt;
    instr_access_state && data_select;
  endsequence
  property p_preempt_idle;
    s_preempt |=> (state_q == bsac_pkg::ST_IDLE) && !o_data_burst_ack;
  endproperty
  a_preempt_idle: assert property (p_preempt_idle)
    else $error("preempted fetch did not pass idle");

  // instruction select only with request, space, no takeover and top address bit clear
  property p_instr_select;
    instr_select |-> i_instr_request && !i_test_takeover && !i_addr[31]
      && !i_instr_request_type;
  endproperty
  a_instr_select: assert property (p_instr_select)
    else $error("instruction select without its conditions");

  // data select only with top address bit set
  property p_data_select;
    data_select |-> i_data_request && i_addr[31] && !i_addr[30]
      && !i_test_takeover;
  endproperty
  a_data_select: assert property (p_data_select)
    else $error("data select without its conditions");

  // entry into instruction state
  property p_enter_instr;
    (state_q == bsac_pkg::ST_IDLE) && instr_select && !data_select
      |=> o_instr_burst_ack;
  endproperty
  a_enter_instr: assert property (p_enter_instr)
    else $error("instruction state not entered");

  // data state left on foreign data request
  property p_data_exit;
    data_access_state && i_data_request && !data_select
      |=> !o_data_burst_ack;
  endproperty
  a_data_exit: assert property (p_data_exit)
    else $error("data state kept on foreign request");

  // instruction load suppressed in data state
  property p_load_suppress;
    data_access_state && !i_data_request |-> !addr_load;
  endproperty
  a_load_suppress: assert property (p_load_suppress)
    else $error("instruction load during data state");

  // delayed load flag set, ready shown unless bus was invalid
  sequence s_instr_load_delayed;
    addr_load && instr_select && !data_access_state;
  endsequence
  property p_instr_load_delayed;
    s_instr_load_delayed |=> instr_load_delayed_q
      && (late.bus_invalid_q || o_instr_ready);
  endproperty
  a_instr_load_delayed: assert property (p_instr_load_delayed)
    else $error("delayed instruction load missing");

  // second burst cycle counts instead of reloading
  property p_count_step;
    addr_increment && !addr_load |=>
      o_mem_addr[LO_W-1:0] == LO_W'($past(o_mem_addr[LO_W-1:0]) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("address did not increment");

  // invalid bus blocks count and ready
  property p_invalid_block;
    late.bus_invalid_q |-> !addr_increment && !o_instr_ready
      && !o_data_ready;
  endproperty
  a_invalid_block: assert property (p_invalid_block)
    else $error("activity after invalid bus cycle");

  // strobe only on write cycles with data ready
  property p_we_gate;
    !o_mem_we_b |-> data_ready && (i_read_write != bsac_pkg::RW_READ);
  endproperty
  a_we_gate: assert property (p_we_gate)
    else $error("write strobe without write ready");

  // a fetch stream to another block drops the instruction state
  property p_instr_exit_foreign;
    instr_access_state && i_instr_request && !instr_select
      |=> !o_instr_burst_ack;
  endproperty
  a_instr_exit_foreign: assert property (p_instr_exit_foreign)
    else $error("instruction state kept on foreign fetch");

  // data burst still requesting keeps the data state
  property p_data_hold;
    data_access_state && late.data_burst_request_q && !i_data_request
      |=> o_data_burst_ack;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data state left while burst still requested");

  // no second load right after a delayed instruction load
  property p_no_reload;
    instr_load_delayed_q && !i_data_request |-> !addr_load;
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("address reloaded in second burst cycle");

  // delayed data load, then data ready unless bus was invalid
  sequence s_data_load_delayed;
    addr_load && data_select && !instr_access_state;
  endsequence
  property p_data_load_delayed;
    s_data_load_delayed |=> data_load_delayed_q && (late.bus_invalid_q || o_data_ready);
  endproperty
  a_data_load_delayed: assert property (p_data_load_delayed)
    else $error("delayed data load missing");

  // an acknowledged burst cycle gives ready one cycle later
  property p_burst_ready;
    instr_access_state && i_instr_burst_request && !i_bus_invalid
      |=> o_instr_ready;
  endproperty
  a_burst_ready: assert property (p_burst_ready)
    else $error("burst cycle without instruction ready");

  // counting never touches the upper address
  property p_upper_held;
    addr_increment && !addr_load |=> $stable(o_mem_addr[LO_W+HI_W-1:LO_W]);
  endproperty
  a_upper_held: assert property (p_upper_held)
    else $error("upper address changed while counting");

endmodule

// >>> bench/bsac_host_model.sv
// processor side model: issues instruction and data requests one cycle at a time
`timescale 1ns/1ps
module bsac_host_model (
  input wire logic i_clk,
  output logic [31:0] o_addr,
  output logic o_instr_request,
  output logic o_instr_request_type,
  output logic o_data_request,
  output logic o_data_request_type_hi,
  output logic o_data_request_type_lo,
  output logic o_instr_burst_request,
  output logic o_data_burst_request,
  output logic o_bus_invalid,
  output logic o_test_takeover,
  output logic o_read_write
);
  // quiet bus from time zero, no request before reset release
  initial begin
    o_addr = 32'h0000_0000;
    {o_instr_request, o_instr_request_type, o_data_request} = 3'h0;
    {o_data_request_type_hi, o_data_request_type_lo, o_instr_burst_request} = 3'h0;
    {o_data_burst_request, o_bus_invalid, o_test_takeover, o_read_write} = 4'h0;
  end
  // one bus cycle: signals change just after the edge and hold a full cycle
  // a slow master is simply a run of cycles with burst request low
  task automatic put(input logic [11:0] cmd, input logic [31:0] addr);
    @(posedge i_clk);
    o_addr <= addr;
    {o_instr_request, o_instr_request_type, o_data_request} <= cmd[11:9];
    {o_data_request_type_hi, o_data_request_type_lo, o_instr_burst_request} <= cmd[8:6];
    {o_data_burst_request, o_bus_invalid, o_test_takeover, o_read_write} <= cmd[5:2];
  endtask
endmodule

// >>> bench/bsac_burst_sram_ctrl_tb.sv
// self-checking bench for the burst sram access control block
`timescale 1ns/1ps
module bsac_burst_sram_ctrl_tb;
  // command bits handed to the host model
  localparam logic [11:0] C_INSTR_REQUEST = 12'h800;
  localparam logic [11:0] C_ITYP = 12'h400;
  localparam logic [11:0] C_DATA_REQUEST = 12'h200;
  localparam logic [11:0] C_DTHI = 12'h100;
  localparam logic [11:0] C_DTLO = 12'h080;
  localparam logic [11:0] C_IBRQ = 12'h040;
  localparam logic [11:0] C_DBRQ = 12'h020;
  localparam logic [11:0] C_BUS_INVALID = 12'h010;
  localparam logic [11:0] C_TT = 12'h008;
  localparam logic [11:0] C_RD = 12'h004;
  // expected flag bits: instr ack, data ack, instr ready, data ready
  localparam logic [3:0] E_IACK = 4'h8;
  localparam logic [3:0] E_DACK = 4'h4;
  localparam logic [3:0] E_INSTR_READY = 4'h2;
  localparam logic [3:0] E_DATA_READY = 4'h1;
  // addresses: own blocks, foreign blocks; 5ff8 sits near the counter wrap
  localparam logic [31:0] A_I = 32'h0000_1234;
  localparam logic [31:0] A_I2 = 32'h0000_0abc;
  localparam logic [31:0] A_IF = 32'h2000_0abc;
  localparam logic [31:0] A_D = 32'h8000_5ff8;
  localparam logic [31:0] A_D2 = 32'h8000_0abc;
  localparam logic [31:0] A_DF = 32'hc000_0abc;
  // one row: inputs for a cycle, outputs seen in the cycle after
  typedef struct packed {
    logic [11:0] cmd;
    logic [31:0] addr;
    logic [3:0] flags;
    logic [15:0] maddr;
  } bsac_row_type;
  bsac_row_type rows [$];
  logic i_clk;
  logic i_rst_b;
  logic [31:0] addr;
  logic instr_request, itype, data_request, dt_hi, dt_lo, instr_burst_request, data_burst_request, bus_invalid, takeover, rw;
  logic o_instr_burst_ack, o_data_burst_ack, o_instr_ready, o_data_ready;
  logic o_data_oe, o_mem_we_b;
  logic [15:0] o_mem_addr;
  int err_total;
  int comparisons;

  // clock at 4 ns period
  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  bsac_host_model host (.i_clk(i_clk), .o_addr(addr), .o_instr_request(instr_request),
    .o_instr_request_type(itype), .o_data_request(data_request), .o_data_request_type_hi(dt_hi),
    .o_data_request_type_lo(dt_lo), .o_instr_burst_request(instr_burst_request), .o_data_burst_request(data_burst_request),
    .o_bus_invalid(bus_invalid), .o_test_takeover(takeover), .o_read_write(rw));

  bsac_burst_sram_ctrl #(.LO_W(8), .HI_W(8)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr),
    .i_instr_request(instr_request), .i_instr_request_type(itype), .i_data_request(data_request),
    .i_data_request_type_lo(dt_lo), .i_data_request_type_hi(dt_hi), .i_instr_burst_request(instr_burst_request),
    .i_data_burst_request(data_burst_request), .i_bus_invalid(bus_invalid), .i_test_takeover(takeover), .i_read_write(rw),
    .o_instr_burst_ack(o_instr_burst_ack), .o_data_burst_ack(o_data_burst_ack),
    .o_instr_ready(o_instr_ready), .o_data_ready(o_data_ready), .o_data_oe(o_data_oe),
    .o_mem_we_b(o_mem_we_b), .o_mem_addr(o_mem_addr));

  // single comparison point, four-state exact
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic add(input logic [11:0] c, input logic [31:0] a, input logic [3:0] f, input logic [15:0] m);
    rows.push_back('{c, a, f, m});
  endtask

  // the one place the run ends
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: whole run needs well under 100 cycles
  initial begin
    #4000;
    err_total++;
    complete_run();
  end

  // main sequence
  initial begin
    bsac_row_type prev;
    logic rw_now;
    err_total = 0;
    comparisons = 0;
    i_rst_b = 1'b0;
    // burst, preempt by data write, data burst with wrap and invalid bus
    add(C_INSTR_REQUEST | C_RD, A_I, E_IACK | E_INSTR_READY, 16'h048d);
    add(C_IBRQ | C_RD, A_I, E_IACK | E_INSTR_READY, 16'h048d);
    add(C_IBRQ | C_RD, A_I, E_IACK | E_INSTR_READY, 16'h048e);
    add(C_DATA_REQUEST | C_IBRQ, A_D, E_INSTR_READY, 16'h048f);
    add(C_DATA_REQUEST | C_IBRQ, A_D, E_DACK | E_DATA_READY, 16'h17fe);
    add(C_DBRQ, A_D, E_DACK | E_DATA_READY, 16'h17fe);
    add(C_DBRQ, A_D, E_DACK | E_DATA_READY, 16'h17ff);
    add(C_DBRQ | C_BUS_INVALID, A_D, E_DACK, 16'h1700);
    add(C_DBRQ, A_D, E_DACK | E_DATA_READY, 16'h1700);
    // instruction request held off until data burst request drops
    add(C_INSTR_REQUEST | C_DBRQ | C_RD, A_I, E_DACK | E_DATA_READY, 16'h1701);
    add(C_INSTR_REQUEST | C_RD, A_I, E_DACK, 16'h1702);
    add(C_INSTR_REQUEST | C_RD, A_I, 4'h0, 16'h1702);
    add(C_INSTR_REQUEST | C_RD, A_I, E_IACK | E_INSTR_READY, 16'h048d);
    add(C_INSTR_REQUEST | C_RD, A_I2, E_IACK, 16'h048d);
    add(C_INSTR_REQUEST | C_RD, A_IF, 4'h0, 16'h02af);
    // refused selects: wrong space, takeover, wrong block
    add(C_INSTR_REQUEST | C_ITYP | C_RD, A_I, 4'h0, 16'h048d);
    add(C_INSTR_REQUEST | C_TT | C_RD, A_I2, 4'h0, 16'h02af);
    add(C_DATA_REQUEST | C_DTLO, A_D, 4'h0, 16'h17fe);
    add(C_DATA_REQUEST | C_DTHI, A_D2, 4'h0, 16'h02af);
    add(C_DATA_REQUEST | C_TT, A_D, 4'h0, 16'h17fe);
    add(C_DATA_REQUEST, A_I, 4'h0, 16'h048d);
    add(C_INSTR_REQUEST | C_RD, A_D2, 4'h0, 16'h02af);
    // data read, foreign data exit, masked first ready
    add(C_DATA_REQUEST | C_RD, A_D, E_DACK | E_DATA_READY, 16'h17fe);
    add(C_DATA_REQUEST | C_RD, A_DF, 4'h0, 16'h17fe);
    add(C_INSTR_REQUEST | C_BUS_INVALID | C_RD, A_I, E_IACK, 16'h048d);
    add(12'h000, A_I, E_IACK, 16'h048d);
    add(C_INSTR_REQUEST | C_RD, A_IF, 4'h0, 16'h02af);
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    // row i is applied while row i-1 results are checked in the low half
    for (int i = 0; i <= rows.size(); i++) begin
      if (i < rows.size()) begin
        host.put(rows[i].cmd, rows[i].addr);
      end else begin
        host.put(12'h000, A_D);
      end
      rw_now = (i < rows.size()) ? rows[i].cmd[2] : 1'b0;
      @(negedge i_clk);
      #1;
      if (i > 0) begin
        prev = rows[i-1];
        check(16'(o_instr_burst_ack), 16'(prev.flags[3]));
        check(16'(o_data_burst_ack), 16'(prev.flags[2]));
        check(16'(o_instr_ready), 16'(prev.flags[1]));
        check(16'(o_data_ready), 16'(prev.flags[0]));
        check(o_mem_addr, prev.maddr);
        check(16'(o_data_oe), 16'(prev.flags[0] & rw_now));
        check(16'(o_mem_we_b), 16'(!(prev.flags[0] & !rw_now)));
      end
    end
    // write strobe stays high in the clock high half
    host.put(C_DATA_REQUEST, A_D);
    host.put(12'h000, A_D);
    #1;
    check(16'(o_mem_we_b), 16'h0001);
    check(16'(o_data_burst_ack), 16'h0001);
    @(negedge i_clk);
    #1;
    check(16'(o_mem_we_b), 16'h0000);
    // reset in mid access clears everything at once
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    #1;
    check(16'(o_data_burst_ack), 16'h0000);
    check(16'(o_data_ready), 16'h0000);
    check(o_mem_addr, 16'h0000);
    @(negedge i_clk);
    #1;
    check(16'(o_mem_we_b), 16'h0001);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check(16'({o_instr_burst_ack, o_data_burst_ack}), 16'h0000);
    complete_run();
  end
endmodule
